// ### rtl/sramc_defines.vh
`ifndef SRAMC_DEFINES_VH
`define SRAMC_DEFINES_VH
// ----------------------------------------
// Array geometry
// ----------------------------------------
`define SRAMC_ADDR_W 5
`define SRAMC_DATA_W 8
// ----------------------------------------
// Bus timing in clock periods (half-period figures doubled)
// ----------------------------------------
`define SRAMC_ADDR_SETUP_HALF 9
`define SRAMC_DATA_SETUP_HALF 11
`define SRAMC_WRITE_WIDTH 2
`define SRAMC_ADDR_HOLD 1
`define SRAMC_DATA_HOLD 1
`define SRAMC_READ_LEAD 1
// ----------------------------------------
// Retention guard time
// ----------------------------------------
`define SRAMC_RETAIN_NS 600
`define SRAMC_CLK_NS 10
`endif

// ### rtl/sramc_delay.v
// ----------------------------------------
// Down-counter giving a done pulse after a load
// ----------------------------------------
module sramc_delay #(
    parameter W = 8
) (
    input wire clk, // System clock
    input wire rst, // Synchronous reset, active high
    input wire load, // Start counting
    input wire [W-1:0] count, // Cycles to wait
    output wire busy, // Counter running
    output wire done // Counter reached one this cycle
);
    reg [W-1:0] cnt; // Remaining cycles

    // Count down to zero after a load
    always @(posedge clk)
    begin
        if (rst)
            cnt <= {W{1'b0}};
        else if (load)
            cnt <= count;
        else if (cnt != {W{1'b0}})
            cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
    end

    assign busy = (cnt != {W{1'b0}});
    assign done = (cnt == {{(W-1){1'b0}}, 1'b1});
endmodule // sramc_delay

// ### rtl/sramc_host.v
`include "sramc_defines.vh"
module sramc_host #(
    parameter ADDR_W = `SRAMC_ADDR_W,
    parameter DATA_W = `SRAMC_DATA_W,
    parameter CLK_NS = `SRAMC_CLK_NS,
    parameter RETAIN_NS = `SRAMC_RETAIN_NS
) (
    input wire clk, // System clock, 100 MHz
    input wire rst, // Synchronous reset, active high
    input wire req_valid, // Access request
    input wire req_write, // 1 write, 0 read
    input wire [ADDR_W-1:0] req_addr, // Word to access
    input wire [DATA_W-1:0] req_wdata, // Data to write
    output wire req_ready, // Request accepted this cycle
    output reg rsp_valid, // Read data valid pulse
    output reg [DATA_W-1:0] rsp_rdata, // Read data
    input wire retain_req, // Ask to enter low-supply retention
    output reg retain_ok, // Supply may be lowered
    input wire supply_good, // Supply back to normal (async)
    input wire rom_enable_output, // Companion ROM enable (async)
    input wire use_rom_enable, // Gate select by ROM enable
    output reg [ADDR_W-1:0] word_address, // Memory address lines
    output reg select_n, // Chip select, active low
    output reg read_strobe_n, // Read strobe, active low
    output reg write_strobe_n, // Write strobe, active low
    input wire [DATA_W-1:0] data_in, // Bus level seen at pins
    output reg [DATA_W-1:0] data_out, // Bus value we drive
    output reg data_oe // High while we drive the bus
);
    // ----------------------------------------
    // Timing constants
    // ----------------------------------------
    // Access wait of 80 ns at 10 ns; a slower part needs a longer wait here
    localparam [7:0] RD_WAIT = 8'h08;
    localparam integer RETAIN_CYC_I = (RETAIN_NS + CLK_NS - 1) / CLK_NS; // Round up
    localparam [7:0] RETAIN_CYC = RETAIN_CYC_I[7:0]; // Guard in cycles
    localparam integer AS_CYC_I = (`SRAMC_ADDR_SETUP_HALF + 1) / 2; // Setup rounded up
    localparam integer DS_EXTRA_I = ((`SRAMC_DATA_SETUP_HALF - `SRAMC_ADDR_SETUP_HALF) + 1) / 2;
    localparam integer WSET_CYC_I = AS_CYC_I + DS_EXTRA_I - 2; // Setup before the strobe falls
    localparam [7:0] WSET_CYC = WSET_CYC_I[7:0]; // Setup phase in cycles
    localparam integer WR_CYC_I = `SRAMC_WRITE_WIDTH;
    localparam [7:0] WR_CYC = WR_CYC_I[7:0]; // Write strobe width in cycles
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_WSET = 4'h1; // Address and data setup
    localparam [3:0] ST_WPUL = 4'h2; // Write strobe low
    localparam [3:0] ST_WHLD = 4'h3; // Address/data hold
    localparam [3:0] ST_RLEAD = 4'h4; // Read strobe before address
    localparam [3:0] ST_RWAIT = 4'h5; // Access wait
    localparam [3:0] ST_RDONE = 4'h6; // Release
    localparam [3:0] ST_DESEL = 4'h7; // Deselect before retention
    localparam [3:0] ST_RETN = 4'h8; // In retention
    localparam [3:0] ST_RECOV = 4'h9; // Deselected after recovery

    reg [3:0] state; // Current state
    reg [3:0] next_state; // Next state
    reg tmr_load; // Start delay
    reg [7:0] tmr_count; // Delay length
    wire tmr_done; // Delay elapsed
    reg [ADDR_W-1:0] hold_addr; // Latched address
    reg rom_en_s1; // Synchroniser stage 1
    reg rom_en_s2; // Synchroniser stage 2
    reg good_s1; // Synchroniser stage 1
    reg good_s2; // Synchroniser stage 2

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Pins from outside our clock domain pass two flops first
    always @(posedge clk)
    begin
        if (rst)
        begin
            rom_en_s1 <= 1'b0;
            rom_en_s2 <= 1'b0;
            good_s1 <= 1'b0;
            good_s2 <= 1'b0;
        end
        else
        begin
            rom_en_s1 <= rom_enable_output;
            rom_en_s2 <= rom_en_s1;
            good_s1 <= supply_good;
            good_s2 <= good_s1;
        end
    end

    sramc_delay #(.W(8)) u_delay (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .count(tmr_count),
        .busy(),
        .done(tmr_done)
    );

    // Accept only in idle; retention requests go first; no precharge gap needed
    assign req_ready = (state == ST_IDLE) && !retain_req;

    // Select may be gated by the ROM enable, else it follows our decode
    wire sel_gate = use_rom_enable ? !rom_en_s2 : 1'b1;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    // The state before each timed phase loads the timer for it
    always @*
    begin
        next_state = state;
        tmr_load = 1'b0;
        tmr_count = 8'h00;
        case (state)
            ST_IDLE:
            begin
                if (retain_req)
                begin
                    next_state = ST_DESEL;
                    tmr_load = 1'b1;
                    tmr_count = RETAIN_CYC;
                end
                else if (req_valid && req_write)
                begin
                    next_state = ST_WSET;
                    tmr_load = 1'b1;
                    tmr_count = WSET_CYC;
                end
                else if (req_valid)
                    next_state = ST_RLEAD;
            end
            ST_WSET:
                if (tmr_done)
                begin
                    next_state = ST_WPUL;
                    tmr_load = 1'b1;
                    tmr_count = WR_CYC;
                end
            ST_WPUL:
                if (tmr_done)
                    next_state = ST_WHLD;
            ST_WHLD:
                next_state = ST_IDLE; // One period hold
            ST_RLEAD:
            begin
                next_state = ST_RWAIT;
                tmr_load = 1'b1;
                tmr_count = RD_WAIT;
            end
            ST_RWAIT:
                if (tmr_done)
                    next_state = ST_RDONE;
            ST_RDONE:
                next_state = ST_IDLE;
            ST_DESEL:
                if (tmr_done)
                    next_state = ST_RETN;
            ST_RETN:
                if (!retain_req && good_s2)
                begin
                    next_state = ST_RECOV;
                    tmr_load = 1'b1;
                    tmr_count = RETAIN_CYC;
                end
            ST_RECOV:
                if (tmr_done)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // All pins registered so the device sees glitch-free strobes
    always @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            word_address <= {ADDR_W{1'b0}};
            hold_addr <= {ADDR_W{1'b0}};
            select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_out <= {DATA_W{1'b0}};
            data_oe <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {DATA_W{1'b0}};
            retain_ok <= 1'b0;
        end
        else
        begin
            state <= next_state;
            rsp_valid <= 1'b0;
            case (next_state)
                ST_WSET:
                begin
                    // Latch only on the take edge; request fields may move afterwards
                    if (state == ST_IDLE)
                    begin
                        // Address and data steady long before the strobe
                        word_address <= req_addr;
                        data_out <= req_wdata;
                        data_oe <= 1'b1;
                        select_n <= !sel_gate;
                        read_strobe_n <= 1'b1; // Read high so the write lands
                    end
                end
                ST_WPUL:
                    write_strobe_n <= 1'b0;
                ST_WHLD:
                    write_strobe_n <= 1'b1; // Data and address held one more period
                ST_RLEAD:
                begin
                    // Strobe first, address next period
                    hold_addr <= req_addr;
                    select_n <= !sel_gate;
                    read_strobe_n <= 1'b0;
                    data_oe <= 1'b0; // Device owns the bus now
                end
                ST_RWAIT:
                    word_address <= hold_addr;
                ST_RDONE:
                begin
                    rsp_rdata <= data_in;
                    rsp_valid <= 1'b1;
                    read_strobe_n <= 1'b1; // Device lets go
                end
                ST_IDLE:
                begin
                    // Idle: deselected, strobes high, nobody drives
                    data_oe <= 1'b0;
                    write_strobe_n <= 1'b1;
                    read_strobe_n <= 1'b1;
                    select_n <= 1'b1;
                    retain_ok <= 1'b0;
                end
                ST_DESEL:
                begin
                    select_n <= 1'b1;
                    data_oe <= 1'b0;
                end
                ST_RETN:
                    retain_ok <= 1'b1;
                ST_RECOV:
                    retain_ok <= 1'b0;
                default:
                    select_n <= 1'b1;
            endcase
        end
    end
endmodule // sramc_host

// ### verif/sramc_host_assertions.sv
module sramc_chk #(
    parameter ADDR_W = 5,
    parameter DATA_W = 8,
    parameter CLK_NS = 10,
    parameter RETAIN_NS = 600
) (
    input wire clk, // System clock
    input wire rst, // Synchronous reset
    input wire select_n, // Chip select
    input wire read_strobe_n, // Read strobe
    input wire write_strobe_n, // Write strobe
    input wire [ADDR_W-1:0] word_address, // Address lines
    input wire [DATA_W-1:0] data_out, // Driven data
    input wire data_oe, // Drive enable
    input wire rsp_valid, // Read result pulse
    input wire retain_ok, // Retention granted
    input wire use_rom_enable, // Gate select by ROM
    input wire rom_enable_output // ROM enable level
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Guard-time counters
    // ----------------------------------------
    localparam int GUARD = RETAIN_NS / CLK_NS;
    int desel_cnt; // Cycles deselected in a row, saturating
    int rec_cnt; // Cycles of recovery guard left
    always @(posedge clk)
    begin
        desel_cnt <= (rst || !select_n) ? 0 : ((desel_cnt > 999) ? desel_cnt : desel_cnt + 1);
        rec_cnt <= rst ? 0 : ($fell(retain_ok) ? GUARD : ((rec_cnt > 0) ? rec_cnt - 1 : 0));
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr_pulse;
        !write_strobe_n [*2] ##1 write_strobe_n;
    endsequence
    sequence s_rd_pulse;
        !read_strobe_n [*8] ##1 (read_strobe_n && rsp_valid);
    endsequence
    sequence s_rom_off;
        (use_rom_enable && rom_enable_output) [*5];
    endsequence
    property p_wr_width; $fell(write_strobe_n) |-> s_wr_pulse; endproperty
    property p_wr_setup; $fell(write_strobe_n) |-> data_oe && !select_n && $past(data_oe, 4)
        && $past(data_out, 4) == data_out && $past(word_address, 4) == word_address; endproperty
    property p_wr_hold; $rose(write_strobe_n) |-> (data_oe && $stable(data_out) && $stable(word_address))
        ##1 !data_oe; endproperty
    property p_rd_len; $fell(read_strobe_n) |=> s_rd_pulse; endproperty
    property p_rd_addr; $fell(read_strobe_n) ##2 1 |-> $stable(word_address) [*7]; endproperty
    property p_rd_clean; !read_strobe_n |-> !select_n && write_strobe_n && !data_oe; endproperty
    property p_rom_gate; s_rom_off |-> select_n; endproperty
    property p_ret_in; $rose(retain_ok) |-> desel_cnt >= GUARD; endproperty
    property p_ret_out; (retain_ok || $fell(retain_ok) || rec_cnt > 0) |-> select_n; endproperty
    a_wr_width: assert property (p_wr_width) else $error("write strobe width wrong");
    a_wr_setup: assert property (p_wr_setup) else $error("write setup short");
    a_wr_hold: assert property (p_wr_hold) else $error("write hold wrong");
    a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");
    a_rd_addr: assert property (p_rd_addr) else $error("read address moved");
    a_rd_clean: assert property (p_rd_clean) else $error("read with drive or write");
    a_rom_gate: assert property (p_rom_gate) else $error("select despite ROM enable");
    a_ret_in: assert property (p_ret_in) else $error("retention entered early");
    a_ret_out: assert property (p_ret_out) else $error("select during retention guard");
endmodule // sramc_chk

bind sramc_host sramc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .CLK_NS(CLK_NS), .RETAIN_NS(RETAIN_NS)) i_chk (
    .clk, .rst, .select_n, .read_strobe_n, .write_strobe_n, .word_address, .data_out, .data_oe,
    .rsp_valid, .retain_ok, .use_rom_enable, .rom_enable_output);

// ### verif/sramc_ram_model.sv
module sramc_ram_model #(
    parameter int ACC_NS = 70
) (
    input wire [4:0] word_address, // Word picked
    input wire select_n, // Chip select
    input wire read_strobe_n, // Read strobe
    input wire write_strobe_n, // Write strobe
    input wire [7:0] bus_level, // Resolved data lines
    output wire [7:0] ram_out, // Word driven on read
    output wire ram_oe // High while driving
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [32]; // 32 words of 8 bits
    // Static decode, no clock; a slow access shows stale data first
    assign #(ACC_NS) ram_out = mem[word_address];
    // Drive only while selected and reading, else float
    assign ram_oe = !select_n && !read_strobe_n;
    // Store only when read is idle, so read wins
    always @*
    begin
        if (!select_n && read_strobe_n && !write_strobe_n)
            mem[word_address] = bus_level;
    end
endmodule // sramc_ram_model

// ### verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, req_valid, req_write, retain_req, supply_good, rom_enable_output, use_rom_enable;
    logic [4:0] req_addr;
    logic [7:0] req_wdata, last_lvl;
    wire req_ready, rsp_valid, retain_ok, select_n, read_strobe_n, write_strobe_n, data_oe, ram_oe;
    wire [7:0] rsp_rdata, data_out, ram_out, bus_level;
    wire [4:0] word_address;
    int err_count, comparisons, cycles, n;
    logic [7:0] mirror [32]; // What each word should hold
    logic [7:0] exp_q [$]; // Expected read results
    // Released lines show the inverse of their last level, never a lucky match
    assign bus_level = data_oe ? data_out : (ram_oe ? ram_out : ~last_lvl);
    sramc_host #(.ADDR_W(5), .DATA_W(8), .CLK_NS(10), .RETAIN_NS(600)) i_dut (.clk, .rst, .req_valid,
        .req_write, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .retain_req, .retain_ok,
        .supply_good, .rom_enable_output, .use_rom_enable, .word_address, .select_n, .read_strobe_n,
        .write_strobe_n, .data_in(bus_level), .data_out, .data_oe);
    sramc_ram_model #(.ACC_NS(70)) i_ram (.word_address, .select_n, .read_strobe_n, .write_strobe_n,
        .bus_level, .ram_out, .ram_oe);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task check(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1)
        begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task finish_test;
        if (err_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Hold the request until ready shows after a clock edge, then note the expected result
    task access(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        check(n < 200, "request not taken");
        if (w)
            mirror[a] = d;
        else
            exp_q.push_back(mirror[a]);
        #1;
        req_valid = 1'b0;
    endtask
    task drain;
        n = 0;
        while (exp_q.size() != 0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        check(exp_q.size() == 0, "read result missing");
        #1;
    endtask
    // Result watcher and timeout
    always @(posedge clk)
    begin
        last_lvl <= bus_level;
        cycles <= cycles + 1;
        if (rsp_valid === 1'b1)
            check(exp_q.size() > 0 && rsp_rdata === exp_q.pop_front(), "read data");
        if (cycles == 6000)
        begin
            err_count++;
            finish_test;
        end
    end
    initial
    begin
        {rst, supply_good} = 2'h3;
        {req_valid, req_write, retain_req, rom_enable_output, use_rom_enable} = 5'h00;
        {req_addr, req_wdata, last_lvl} = 21'h00_0000;
        {err_count, comparisons, cycles} = {32'h0, 32'h0, 32'h0};
        void'($urandom(5));
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        check(select_n === 1'b1 && data_oe === 1'b0 && read_strobe_n === 1'b1, "idle pins");
        for (int i = 0; i < 32; i++) access(1'b1, i[4:0], 8'($urandom));
        for (int i = 31; i >= 0; i--) access(1'b0, i[4:0], 8'h00);
        access(1'b1, 5'h1f, 8'($urandom));
        access(1'b0, 5'h1f, 8'h00);
        drain;
        // Retention: deselect guard, supply dip, recovery guard
        retain_req = 1'b1;
        for (n = 0; n < 100 && retain_ok !== 1'b1; n++) @(posedge clk);
        check(retain_ok === 1'b1 && select_n === 1'b1, "retention not granted");
        #1 supply_good = 1'b0;
        {use_rom_enable, rom_enable_output} = 2'h3;
        repeat (8) @(posedge clk);
        #1 {supply_good, retain_req, rom_enable_output} = 3'h4;
        for (int i = 0; i < 32; i++) access(1'b0, 5'($urandom), 8'h00);
        drain;
        finish_test;
    end
endmodule // testbench
